// >>> serial_port_map.svh
// Constants for the dual mode serial control port.
// Assumes inclusion by serial_port_pkg, the register store, the port module and the bench.
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

`define SLV_ADDR_HI        5'h11
`define READ_START_ADDR    7'h09
`define READ_LAST_ADDR     7'h0a
`define NUM_CTRL_REGS      11
`define CTRL_ADDR_W        7
`define GEN_CALL_ADDR      7'h00
`define CLK_PERIOD_PS      25000
`define RESET_MIN_CLOCKS   40

`endif

// >>> serial_port_pkg.sv
// Types shared by the serial control port and its register store.
// Assumes the constants header sits in the same folder.
`include "serial_port_map.svh"

package serial_port_pkg;

    typedef logic [`CTRL_ADDR_W-1:0] reg_addr_t;

    typedef struct packed {
        logic      we;
        reg_addr_t addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic scl_or_sck;
        logic sda_or_si;
        logic cs_n_or_sa;
    } link_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_RACK  = 3'b101,
        ST_SKIP  = 3'b110
    } twi_state_t;

endpackage : serial_port_pkg

// >>> ctrl_reg_store.sv
// Control register store, 11 bytes, with registered read data.
// Assumes one write port and one read port on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.svh"

module ctrl_reg_store
    import serial_port_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Write side
    input  wire serial_port_pkg::reg_wr_t wr_i,
    // Read side
    input  wire serial_port_pkg::reg_addr_t rd_addr_i,
    output logic [7:0]                  rd_data_o,
    // Flat view of all registers
    output logic [8*`NUM_CTRL_REGS-1:0] regs_o
);
    logic [7:0] mem_ff [`NUM_CTRL_REGS];

    genvar g;
    generate
        for (g = 0; g < `NUM_CTRL_REGS; g++) begin : g_reg
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mem_ff[g] <= 8'h00;
                end else if (wr_i.we && wr_i.addr == 7'(g)) begin
                    mem_ff[g] <= wr_i.data;
                end
            end
            assign regs_o[8*g +: 8] = mem_ff[g];
        end
    endgenerate

    // Out of range reads return zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_addr_i < 7'(`NUM_CTRL_REGS)) begin
            rd_data_o <= mem_ff[rd_addr_i[3:0]];
        end else begin
            rd_data_o <= 8'h00;
        end
    end

endmodule : ctrl_reg_store
`default_nettype wire

// >>> serial_ctrl_port.sv
// Dual mode serial control port: two-wire slave or chip-select serial port.
// Assumes link pins are asynchronous to clk_i and link clock is far below clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.svh"

module serial_ctrl_port
    import serial_port_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Mode and shared pins
    input  wire logic                   serial_mode_select_i,
    input  wire serial_port_pkg::link_pins_t pins_i,
    // Two-wire data pin driver (open drain: enable pulls low)
    output logic                        sda_o,
    output logic                        sda_oe_o,
    // Chip-select serial data output
    output logic                        sdo_o,
    output logic                        sdo_oe_o,
    // Control register contents
    output logic [8*`NUM_CTRL_REGS-1:0] ctrl_regs_o
);
    import serial_port_pkg::*;

    link_pins_t  s1_ff, s2_ff, s3_ff;
    reg_wr_t     nxt_wr;
    reg_wr_t     wr_ff;
    reg_addr_t   addr_ff;
    logic [7:0]  rd_data;
    logic [7:0]  shift_ff;
    logic [7:0]  tx_ff;
    logic [3:0]  bit_ff;
    logic        first_ff;
    logic        rd_dir_ff;
    logic        load_tx_ff;
    logic        load_tx2_ff;
    twi_state_t  state_ff;
    logic        mode_ff;

    // Two flip-flops before any logic, third stage for edge detection
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff <= '1;
            s2_ff <= '1;
            s3_ff <= '1;
        end else begin
            s1_ff <= pins_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Mode pin is a level; pull-up makes chip-select the safe default
    logic mode_s1_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_s1_ff <= 1'b1;
            mode_ff    <= 1'b1;
        end else begin
            mode_s1_ff <= serial_mode_select_i;
            mode_ff    <= mode_s1_ff;
        end
    end

    wire clk_rise = s2_ff.scl_or_sck & ~s3_ff.scl_or_sck;
    wire clk_fall = ~s2_ff.scl_or_sck & s3_ff.scl_or_sck;
    wire din      = s2_ff.sda_or_si;
    wire cs_act   = mode_ff & ~s2_ff.cs_n_or_sa;
    wire start_c  = ~mode_ff & s2_ff.scl_or_sck & s3_ff.sda_or_si & ~din;
    wire stop_c   = ~mode_ff & s2_ff.scl_or_sck & ~s3_ff.sda_or_si & din;
    wire [7:0] shifted = {shift_ff[6:0], din};

    ctrl_reg_store u_store (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (wr_ff),
        .rd_addr_i (addr_ff),
        .rd_data_o (rd_data),
        .regs_o    (ctrl_regs_o)
    );

    // Port state for both modes; two-wire side is slave only, never drives the clock line
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff   <= ST_IDLE;
            shift_ff   <= 8'h00;
            bit_ff     <= 4'h0;
            first_ff   <= 1'b0;
            rd_dir_ff  <= 1'b0;
            addr_ff    <= '0;
            wr_ff      <= '0;
            load_tx_ff <= 1'b0;
            sda_oe_o   <= 1'b0;
            tx_ff      <= 8'h00;
            load_tx2_ff <= 1'b0;
        end else begin
            wr_ff      <= nxt_wr;
            load_tx_ff <= 1'b0;
            // Store read data is registered: wait one more cycle for it
            load_tx2_ff <= load_tx_ff;
            if (wr_ff.we) begin
                addr_ff <= addr_ff + 7'h01;
            end
            if (load_tx2_ff) begin
                tx_ff <= rd_data;
            end
            if (mode_ff) begin
                sda_oe_o <= 1'b0;
                state_ff <= ST_IDLE;
                if (!cs_act) begin
                    bit_ff   <= 4'h0;
                    first_ff <= 1'b1;
                end else if (clk_rise) begin
                    shift_ff <= shifted;
                    bit_ff   <= (bit_ff == 4'h7) ? 4'h0 : bit_ff + 4'h1;
                    if (bit_ff == 4'h7 && first_ff) begin
                        first_ff  <= 1'b0;
                        rd_dir_ff <= shifted[7];
                        addr_ff   <= shifted[6:0];
                        load_tx_ff <= shifted[7];
                    end else if (bit_ff == 4'h7 && rd_dir_ff) begin
                        addr_ff    <= addr_ff + 7'h01;
                        load_tx_ff <= 1'b1;
                    end
                // Fall before a byte's first rise shows the freshly loaded MSB
                end else if (clk_fall && rd_dir_ff && !first_ff && bit_ff != 4'h0) begin
                    tx_ff <= {tx_ff[6:0], 1'b0};
                end
            end else if (start_c) begin
                state_ff <= ST_ADDR;
                bit_ff   <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_c) begin
                state_ff <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (clk_rise) begin
                case (state_ff)
                    ST_ADDR, ST_WDATA: begin
                        shift_ff <= shifted;
                        bit_ff   <= bit_ff + 4'h1;
                    end
                    ST_RACK: begin
                        // Master NACK ends the read
                        state_ff <= din ? ST_SKIP : ST_RDATA;
                        addr_ff  <= addr_ff + 7'h01;
                        load_tx_ff <= ~din;
                    end
                    default: begin
                    end
                endcase
            end else if (clk_fall) begin
                case (state_ff)
                    ST_ADDR: begin
                        if (bit_ff == 4'h8) begin
                            bit_ff <= 4'h0;
                            if (shift_ff[7:3] == `SLV_ADDR_HI && shift_ff[2] == s2_ff.cs_n_or_sa
                                && shift_ff[1] == 1'b0 && shift_ff[7:1] != `GEN_CALL_ADDR) begin
                                sda_oe_o  <= 1'b1;
                                rd_dir_ff <= shift_ff[0];
                                first_ff  <= 1'b1;
                                state_ff  <= ST_ACK;
                                if (shift_ff[0]) begin
                                    addr_ff    <= `READ_START_ADDR;
                                    load_tx_ff <= 1'b1;
                                end
                            end else begin
                                state_ff <= ST_SKIP;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (bit_ff == 4'h8) begin
                            bit_ff   <= 4'h0;
                            sda_oe_o <= 1'b1;
                            state_ff <= ST_ACK;
                            if (first_ff) begin
                                addr_ff  <= shift_ff[6:0];
                                first_ff <= 1'b0;
                            end
                        end
                    end
                    ST_ACK: begin
                        sda_oe_o <= rd_dir_ff & ~tx_ff[7];
                        // Read has put out its MSB here; write counts from zero
                        bit_ff   <= rd_dir_ff ? 4'h1 : 4'h0;
                        state_ff <= rd_dir_ff ? ST_RDATA : ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (bit_ff == 4'h8) begin
                            sda_oe_o <= 1'b0;
                            bit_ff   <= 4'h0;
                            state_ff <= ST_RACK;
                        end else begin
                            sda_oe_o <= ~tx_ff[7 - bit_ff[2:0]];
                            bit_ff   <= bit_ff + 4'h1;
                        end
                    end
                    ST_RACK: begin
                        sda_oe_o <= ~tx_ff[7];
                        bit_ff   <= 4'h1;
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register write strobe, one cycle per completed data byte
    always_comb begin
        nxt_wr      = '0;
        nxt_wr.addr = addr_ff;
        nxt_wr.data = shift_ff;
        if (mode_ff) begin
            nxt_wr.data = shifted;
            nxt_wr.we   = cs_act & clk_rise & (bit_ff == 4'h7)
                          & ~first_ff & ~rd_dir_ff;
        end else begin
            nxt_wr.we = ~start_c & ~stop_c & clk_fall & (state_ff == ST_WDATA)
                        & (bit_ff == 4'h8) & ~first_ff;
        end
    end

    assign sda_o    = 1'b0;
    assign sdo_o    = tx_ff[7];
    assign sdo_oe_o = cs_act;

    a_sdo_hiz_twi: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mode_ff |-> !sdo_oe_o) else $error("Serial output driven in two-wire mode");
    a_no_wr_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode_ff && rd_dir_ff && !first_ff) |=> !wr_ff.we) else $error("Write in read");
    a_rd_start_id: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!mode_ff && state_ff == ST_ADDR && clk_fall && bit_ff == 4'h8 && shift_ff[0]
         && sda_oe_o == 1'b0 && $past(1'b1)) ##1 (state_ff == ST_ACK) |-> addr_ff == 7'h09)
        else $error("Read did not start at 09H");
    a_gen_call_nack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!mode_ff && state_ff == ST_ADDR && clk_fall && bit_ff == 4'h8
         && shift_ff[7:1] == 7'h00 && !start_c && !stop_c) |=> state_ff == ST_SKIP)
        else $error("General call acknowledged");
    a_addr_incr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_ff.we && !load_tx_ff && !(mode_ff && cs_act && clk_rise && bit_ff == 4'h7))
        |=> addr_ff == $past(addr_ff) + 7'h01) else $error("Address not incremented");
    a_cs_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode_ff && !cs_act) |=> !wr_ff.we) else $error("Write without chip select");
    a_cmd_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cs_act && clk_rise && bit_ff == 4'h7 && first_ff) |=>
        (addr_ff == $past(shifted[6:0]) && rd_dir_ff == $past(shifted[7])))
        else $error("Command byte misdecoded");
    a_ack_wrong_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!mode_ff && state_ff == ST_ADDR && clk_fall && bit_ff == 4'h8 && !start_c && !stop_c
         && shift_ff[7:3] != 5'h11) |=> !sda_oe_o) else $error("Foreign address acked");
    // Slave only: the line is pulled low just for acknowledge or read data
    a_twi_slave_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sda_oe_o |-> (sda_o == 1'b0 && (state_ff == ST_ACK || state_ff == ST_RDATA)))
        else $error("Data line driven outside acknowledge or read");

endmodule : serial_ctrl_port
`default_nettype wire

// >>> host_serial_model.sv
// Host side serial master: two-wire master and chip-select master.
// Assumes the bench resolves the open-drain data line and the output pin.
`timescale 1ns/1ps
`default_nettype none

module host_serial_model (
    // Clock
    input  wire logic clk_i,
    // Resolved lines seen by the host
    input  wire logic sda_i,
    input  wire logic so_i,
    // Lines driven by the host
    output var logic  scl_o,
    output var logic  sda_o,
    output var logic  sel_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        sel_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic i2c_start();
        sda_o <= 1'b1;
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b0;
        tick(8);
        scl_o <= 1'b0;
        tick(4);
    endtask : i2c_start

    task automatic i2c_stop();
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b1;
        tick(8);
    endtask : i2c_stop

    // Data moves only with the clock low; high time of 8 cycles
    task automatic i2c_bit(input logic b, output logic r);
        sda_o <= b;
        tick(4);
        scl_o <= 1'b1;
        tick(6);
        r = sda_i;
        tick(2);
        scl_o <= 1'b0;
        tick(4);
    endtask : i2c_bit

    task automatic i2c_byte(input logic [7:0] b, input logic ack_in,
                            output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
        i2c_bit(ack_in, ack);
    endtask : i2c_byte

    // Extra ticks keep select setup and hold above 150 ns
    task automatic sio_select(input logic lvl);
        tick(4);
        sel_o <= lvl;
        tick(8);
    endtask : sio_select

    // Change on the fall, read late in the high phase
    task automatic sio_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            scl_o <= 1'b0;
            sda_o <= tx[i];
            tick(4);
            scl_o <= 1'b1;
            tick(4);
            rx[i] = so_i;
        end
    endtask : sio_byte
endmodule : host_serial_model

`default_nettype wire

// >>> dual_mode_serial_control_port_tb.sv
// Self-checking bench for the dual mode serial control port.
// Assumes the package, header, design and host model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.svh"

module dual_mode_serial_control_port_tb;
    import serial_port_pkg::*;
    logic                        clk = 1'b0;
    logic                        rst_n;
    logic                        mode;
    link_pins_t                  pins;
    logic                        scl, sda_m, sel, sda_line, so_line, so_q;
    logic                        sda_o, sda_oe, sdo, sdo_oe;
    logic [8*`NUM_CTRL_REGS-1:0] regs;
    logic [7:0]                  exp_q [0:10];
    int                          errors;
    int                          total_checks;

    always #12.5 clk = ~clk;
    // Open drain with pull-up; an undriven output shows a moving value
    assign sda_line = sda_m & (sda_oe ? sda_o : 1'b1);
    assign so_line = sdo_oe ? sdo : ~so_q;
    assign pins = '{scl_or_sck: scl, sda_or_si: sda_line, cs_n_or_sa: sel};
    always_ff @(posedge clk) so_q <= so_line;

    serial_ctrl_port dut (.clk_i(clk), .rst_n_i(rst_n), .serial_mode_select_i(mode),
        .pins_i(pins), .sda_o(sda_o), .sda_oe_o(sda_oe), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .ctrl_regs_o(regs));
    host_serial_model host (.clk_i(clk), .sda_i(sda_line), .so_i(so_line),
        .scl_o(scl), .sda_o(sda_m), .sel_o(sel));

    task automatic check(input logic [7:0] seen, input logic [7:0] expv, input string what);
        total_checks++;
        if (seen !== expv) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expv);
        end
    endtask : check

    task automatic check_regs();
        for (int n = 0; n < `NUM_CTRL_REGS; n++) check(regs[8*n +: 8], exp_q[n], "register");
    endtask : check_regs

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic t_reset();
        check_regs();
        check({7'h00, sda_oe}, 8'h00, "ack idle");
        check({7'h00, sdo_oe}, 8'h00, "out idle");
        $display("test reset done");
    endtask : t_reset

    task automatic t_i2c_write();
        logic [7:0] r, d;
        logic       ack;
        logic [6:0] a;
        mode <= 1'b0;
        for (int sa = 0; sa < 2; sa++) begin
            host.sio_select(sa[0]);
            a = sa[0] ? 7'h09 : 7'h02;
            host.i2c_start();
            host.i2c_byte(sa[0] ? 8'h8c : 8'h88, 1'b1, r, ack);
            check({7'h00, ack}, 8'h00, "addr ack");
            host.i2c_byte({1'b0, a}, 1'b1, r, ack);
            check({7'h00, ack}, 8'h00, "start ack");
            for (int k = 0; k < 3; k++) begin
                d = 8'ha5 ^ 8'(16 * sa + k);
                host.i2c_byte(d, 1'b1, r, ack);
                if (a + k <= 10) begin
                    exp_q[a+k] = d;
                    check({7'h00, ack}, 8'h00, "data ack");
                end
            end
            check({7'h00, sdo_oe}, 8'h00, "out undriven");
            host.i2c_stop();
            check_regs();
        end
        $display("test i2c write done");
    endtask : t_i2c_write

    task automatic t_i2c_refuse();
        logic [7:0]  r;
        logic        ack;
        logic [31:0] bad;
        bad = 32'h8c008a98;
        host.sio_select(1'b0);
        for (int i = 0; i < 4; i++) begin
            host.i2c_start();
            host.i2c_byte(bad[8*i +: 8], 1'b1, r, ack);
            check({7'h00, ack}, 8'h01, "foreign addr");
            host.i2c_byte(8'h00, 1'b1, r, ack);
            host.i2c_byte(8'hee, 1'b1, r, ack);
            check({7'h00, ack}, 8'h01, "ignored data");
            host.i2c_stop();
        end
        check_regs();
        $display("test i2c refuse done");
    endtask : t_i2c_refuse

    task automatic t_i2c_read();
        logic [7:0] r;
        logic       ack;
        host.i2c_start();
        host.i2c_byte(8'h89, 1'b1, r, ack);
        check({7'h00, ack}, 8'h00, "read addr ack");
        host.i2c_byte(8'hff, 1'b0, r, ack);
        check(r, exp_q[9], "first id byte");
        host.i2c_byte(8'hff, 1'b1, r, ack);
        check(r, exp_q[10], "second id byte");
        host.i2c_stop();
        $display("test i2c read done");
    endtask : t_i2c_read

    task automatic t_sio();
        logic [7:0] r;
        host.sio_select(1'b1);
        mode <= 1'b1;
        host.tick(8);
        host.sio_byte(8'h01, r);
        host.sio_byte(8'h5a, r);
        check_regs();
        host.sio_select(1'b0);
        check({7'h00, sdo_oe}, 8'h01, "out driven");
        host.sio_byte(8'h00, r);
        host.sio_byte(8'hc3, r);
        host.sio_byte(8'h81, r);
        exp_q[0] = 8'hc3;
        exp_q[1] = 8'h81;
        host.sio_select(1'b1);
        check_regs();
        host.sio_select(1'b0);
        host.sio_byte(8'h80, r);
        for (int n = 0; n < 11; n++) begin
            host.sio_byte(8'h3c, r);
            check(r, exp_q[n], "read back");
        end
        host.sio_select(1'b1);
        check_regs();
        $display("test sio done");
    endtask : t_sio

    // Reset in mid-run: store clears, port works again from a clean state
    task automatic t_mid_reset();
        logic [7:0] r;
        rst_n <= 1'b0;
        repeat (48) @(posedge clk);
        rst_n <= 1'b1;
        for (int n = 0; n < `NUM_CTRL_REGS; n++) exp_q[n] = 8'h00;
        repeat (2) @(posedge clk);
        check_regs();
        check({7'h00, sdo_oe}, 8'h00, "out idle again");
        check({7'h00, sda_oe}, 8'h00, "ack idle again");
        host.sio_select(1'b0);
        host.sio_byte(8'h09, r);
        host.sio_byte(8'h3c, r);
        host.sio_select(1'b1);
        exp_q[9] = 8'h3c;
        check_regs();
        $display("test mid reset done");
    endtask : t_mid_reset

    initial begin
        rst_n = 1'b0;
        mode = 1'b1;
        errors = 0;
        total_checks = 0;
        for (int n = 0; n < 11; n++) exp_q[n] = 8'h00;
        repeat (48) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_i2c_write();
        t_i2c_refuse();
        t_i2c_read();
        t_sio();
        t_mid_reset();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        tally_and_finish();
    end
endmodule : dual_mode_serial_control_port_tb

`default_nettype wire
